// >>> core/csm_defs.vh
// register map, field positions and reset values of the compare state / timer control block
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef CSM_DEFS_VH
`define CSM_DEFS_VH

`define CSM_ADR_W          8
`define CSM_OFS_MODIFY     8'h10
`define CSM_OFS_STATE      8'h14
`define CSM_OFS_TCTR       8'h30
`define CSM_OFS_RUNCTL     8'h34

// compare_state_modify: set strobes and clear strobes per channel 0..3
`define CSM_SET_CH0        0
`define CSM_SET_CH1        1
`define CSM_SET_CH2        2
`define CSM_SET_CH3        6
`define CSM_CLR_CH0        8
`define CSM_CLR_CH1        9
`define CSM_CLR_CH2        10
`define CSM_CLR_CH3        14

// timer_control_zero fields
`define CSM_T0_CLK_LSB     0
`define CSM_T0_PRE         3
`define CSM_T0_RUN         4
`define CSM_T0_STE         5
`define CSM_COUNT_DIRECTION           6
`define CSM_CTM            7
`define CSM_T1_CLK_LSB     8
`define CSM_T1_PRE         11
`define CSM_T1_RUN         12
`define CSM_T1_STE         13
`define CSM_TCTR_RST       16'h0000
`define CSM_STATE_RST      4'h0

// run control strobes (write-only)
`define CSM_RC_T0_START    0
`define CSM_RC_T0_STOP     1
`define CSM_RC_T0_STE      2
`define CSM_RC_T1_START    8
`define CSM_RC_T1_STOP     9
`define CSM_RC_T1_STE      10

// prescaler
`define CSM_CNT_W          15
`define CSM_EXTRA_SHIFT    8

`endif

// >>> core/csm_prescale.v
// clock enable divider for one compare timer: 2^sel, times 256 when extra is set
// assumes sel and extra only change while run_i is low
`include "csm_defs.vh"

module csm_prescale
(
   // clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // control
   input  wire       run_i,
   input  wire [2:0] sel_i,
   input  wire       extra_i,
   // enable out
   output reg        tick_o
);

   reg  [`CSM_CNT_W-1:0] count_r;
   wire [`CSM_CNT_W-1:0] base;
   wire [`CSM_CNT_W-1:0] limit;

   assign base  = {{(`CSM_CNT_W-1){1'b0}}, 1'b1} << sel_i;
   assign limit = (extra_i ? (base << `CSM_EXTRA_SHIFT) : base) - {{(`CSM_CNT_W-1){1'b0}}, 1'b1};

   always @(posedge clk_i)
   begin
      if (rst_i || !run_i)
      begin
         count_r <= {`CSM_CNT_W{1'b0}};
         tick_o  <= 1'b0;
      end
      else if (count_r == limit)
      begin
         count_r <= {`CSM_CNT_W{1'b0}};
         tick_o  <= 1'b1;
      end
      else
      begin
         count_r <= count_r + {{(`CSM_CNT_W-1){1'b0}}, 1'b1};
         tick_o  <= 1'b0;
      end
   end

endmodule

// >>> core/csm_top.v
// compare state modification strobes and timer control register, wishbone slave
// assumes one 40 MHz clock; hardware stop, direction and shadow-done come from same-clock logic
//
// Function
// R1 - bit 8 one clears channel 0 state
// R2 - bit 9 clears channel 1, stores nothing
// R3 - bit 10 clears channel 2, stores nothing
// R4 - bit 14 clears channel 3, stores nothing
// R5 - one write changes several channel states
// R6 - first timer clock fields locked while running
// R7 - second timer clock fields locked while running
// R8 - 16-bit control register at 0x30, reset zero
// R9 - bits 0,1,2,6 set channel states 0..3
// R10 - first timer clock is 2^sel, optional /256
// R11 - concurrent start/stop/hardware stop leaves run unchanged
// R12 - set and clear together leave state unchanged
//
// Chosen here: the Wishbone interface to the registers.
`include "csm_defs.vh"

module csm_top
(
   // clock and reset
   input  wire                  clk_i,
   input  wire                  rst_i,
   // wishbone slave
   input  wire                  cyc_i,
   input  wire                  stb_i,
   input  wire                  we_i,
   input  wire [`CSM_ADR_W-1:0] adr_i,
   input  wire [3:0]            sel_i,
   input  wire [31:0]           dat_i,
   output reg  [31:0]           dat_o,
   output reg                   ack_o,
   // timer side
   input  wire                  first_timer_hw_stop_i,
   input  wire                  second_timer_hw_stop_i,
   input  wire                  first_timer_shadow_done_i,
   input  wire                  second_timer_shadow_done_i,
   input  wire                  count_direction_i,
   // outputs
   output reg  [3:0]            chan_compare_state_o,
   output reg                   first_timer_run_o,
   output reg                   second_timer_run_o,
   output reg                   first_timer_shadow_enable_o,
   output reg                   second_timer_shadow_enable_o,
   output wire                  first_timer_tick_o,
   output wire                  second_timer_tick_o
);

   // run bit update: any two sources at once cancel
   function run_next;
      input cur;
      input start;
      input stop;
      input hw_stop;
      reg [1:0] n;
      begin
         n = {1'b0, start} + {1'b0, stop} + {1'b0, hw_stop};
         if (n > 2'd1)
            run_next = cur;
         else if (start)
            run_next = 1'b1;
         else if (stop || hw_stop)
            run_next = 1'b0;
         else
            run_next = cur;
      end
   endfunction

   // per-channel strobe decode: set and clear together cancel
   function chan_next;
      input cur;
      input set_s;
      input clr_s;
      begin
         if (set_s && clr_s)
            chan_next = cur; // [R12]
         else if (set_s)
            chan_next = 1'b1; // [R9]
         else if (clr_s)
            chan_next = 1'b0; // [R1] [R2] [R3] [R4]
         else
            chan_next = cur;
      end
   endfunction

   // byte address to register decode, low two bits ignored
   function adr_hit;
      input [`CSM_ADR_W-1:0] adr;
      input [`CSM_ADR_W-1:0] ofs;
      begin
         adr_hit = ({adr[`CSM_ADR_W-1:2], 2'b00} == ofs);
      end
   endfunction

   reg  [2:0] first_timer_clock_select_r;
   reg        first_timer_extra_prescale_r;
   reg  [2:0] second_timer_clock_select_r;
   reg        second_timer_extra_prescale_r;
   reg        count_mode_r;
   reg        count_direction_r;
   wire [3:0] state_nxt;
   reg  [31:0] rd_nxt;

   wire       acc     = cyc_i && stb_i && !ack_o;
   wire       wr      = acc && we_i;
   wire [7:0] adr_w   = {adr_i[`CSM_ADR_W-1:2], 2'b00};
   wire [15:0] be_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   wire [15:0] wdat   = dat_i[15:0] & be_mask;
   wire       wr_mod  = wr && adr_hit(adr_i, `CSM_OFS_MODIFY);
   wire       wr_tctr = wr && adr_hit(adr_i, `CSM_OFS_TCTR);
   wire       wr_rc   = wr && adr_hit(adr_i, `CSM_OFS_RUNCTL);
   wire [3:0] set_v   = wr_mod ? {wdat[`CSM_SET_CH3], wdat[`CSM_SET_CH2],
                                  wdat[`CSM_SET_CH1], wdat[`CSM_SET_CH0]} : 4'h0; // [R9]
   wire [3:0] clr_v   = wr_mod ? {wdat[`CSM_CLR_CH3], wdat[`CSM_CLR_CH2],
                                  wdat[`CSM_CLR_CH1], wdat[`CSM_CLR_CH0]} : 4'h0; // [R1] [R2] [R3] [R4]
   wire       t0_start = wr_rc && wdat[`CSM_RC_T0_START];
   wire       t0_stop  = wr_rc && wdat[`CSM_RC_T0_STOP];
   wire       t1_start = wr_rc && wdat[`CSM_RC_T1_START];
   wire       t1_stop  = wr_rc && wdat[`CSM_RC_T1_STOP];
   wire [15:0] tctr_view;
   // reset image of the control register, used for the clock select, prescale and count mode field resets
   wire [15:0] tctr_rst = `CSM_TCTR_RST;

   assign tctr_view = {2'b00, second_timer_shadow_enable_o, second_timer_run_o,
                       second_timer_extra_prescale_r, second_timer_clock_select_r,
                       count_mode_r, count_direction_r, first_timer_shadow_enable_o,
                       first_timer_run_o, first_timer_extra_prescale_r,
                       first_timer_clock_select_r};

   // each channel decides on its own strobes, so one write may touch all four
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_chan
         assign state_nxt[g] = chan_next(chan_compare_state_o[g], set_v[g], clr_v[g]); // [R5]
      end
   endgenerate

   // write-only strobe registers read back as zero
   always @*
   begin
      case (adr_w)
         `CSM_OFS_STATE: rd_nxt = {28'h0000000, chan_compare_state_o};
         `CSM_OFS_TCTR:  rd_nxt = {16'h0000, tctr_view}; // [R8]
         default:        rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o                        <= 1'b0;
         dat_o                        <= 32'h00000000;
         chan_compare_state_o         <= `CSM_STATE_RST;
         first_timer_clock_select_r   <= tctr_rst[`CSM_T0_CLK_LSB+2:`CSM_T0_CLK_LSB];
         first_timer_extra_prescale_r <= tctr_rst[`CSM_T0_PRE]; // [R8]
         second_timer_clock_select_r  <= tctr_rst[`CSM_T1_CLK_LSB+2:`CSM_T1_CLK_LSB];
         second_timer_extra_prescale_r <= tctr_rst[`CSM_T1_PRE];
         count_mode_r                 <= tctr_rst[`CSM_CTM];
         count_direction_r            <= 1'b0;
         first_timer_run_o            <= 1'b0;
         second_timer_run_o           <= 1'b0;
         first_timer_shadow_enable_o  <= 1'b0;
         second_timer_shadow_enable_o <= 1'b0;
      end
      else
      begin
         ack_o                <= acc;
         dat_o                <= (acc && !we_i) ? rd_nxt : 32'h00000000;
         chan_compare_state_o <= state_nxt;
         count_direction_r    <= count_direction_i;
         if (wr_tctr && sel_i[0])
         begin
            count_mode_r <= wdat[`CSM_CTM];
            if (!first_timer_run_o)
            begin
               first_timer_clock_select_r   <= wdat[`CSM_T0_CLK_LSB+2:`CSM_T0_CLK_LSB]; // [R6]
               first_timer_extra_prescale_r <= wdat[`CSM_T0_PRE]; // [R6]
            end
         end
         if (wr_tctr && sel_i[1] && !second_timer_run_o)
         begin
            second_timer_clock_select_r   <= wdat[`CSM_T1_CLK_LSB+2:`CSM_T1_CLK_LSB]; // [R7]
            second_timer_extra_prescale_r <= wdat[`CSM_T1_PRE]; // [R7]
         end
         first_timer_run_o  <= run_next(first_timer_run_o, t0_start, t0_stop,
                                        first_timer_hw_stop_i); // [R11]
         second_timer_run_o <= run_next(second_timer_run_o, t1_start, t1_stop,
                                        second_timer_hw_stop_i); // [R11]
         // a request in the same cycle as the transfer wins, so it is not lost
         if (wr_rc && wdat[`CSM_RC_T0_STE])
            first_timer_shadow_enable_o <= 1'b1;
         else if (first_timer_shadow_done_i)
            first_timer_shadow_enable_o <= 1'b0;
         if (wr_rc && wdat[`CSM_RC_T1_STE])
            second_timer_shadow_enable_o <= 1'b1;
         else if (second_timer_shadow_done_i)
            second_timer_shadow_enable_o <= 1'b0;
      end
   end

   csm_prescale u_first_div
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (first_timer_run_o),
      .sel_i   (first_timer_clock_select_r),
      .extra_i (first_timer_extra_prescale_r),
      .tick_o  (first_timer_tick_o)
   ); // [R10]

   csm_prescale u_second_div
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (second_timer_run_o),
      .sel_i   (second_timer_clock_select_r),
      .extra_i (second_timer_extra_prescale_r),
      .tick_o  (second_timer_tick_o)
   );

endmodule

// >>> testbench/compare_state_modify_timer_ctrl_tb.sv
// self-checking bench for csm_top against a reference model
// assumes the checker is bound from its own file
`include "csm_defs.vh"
module compare_state_modify_timer_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, hw_i = 0;
   logic        sd_i = 0, dir_i = 0;
   logic [7:0]  adr_i = 0;
   logic [31:0] dat_i = 0;
   logic [15:0] rd, lf = 16'h002c, pat[$] = '{16'h0047, 16'h0100, 16'h4747, 16'h4600, 16'h0707};
   logic [3:0]  es = 4'h0, sel_i = 4'h3, bs = 4'h3;
   wire  [31:0] dat_o;
   wire  [3:0]  st;
   wire         ack_o, run0, tk0, run1, tk1, se0, se1;
   int          fail_count = 0, tests_run = 0, n, sp[4] = '{0, 1, 2, 6};
   csm_top dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .first_timer_hw_stop_i(hw_i), .second_timer_hw_stop_i(1'b0),
      .first_timer_shadow_done_i(sd_i), .second_timer_shadow_done_i(1'b0),
      .count_direction_i(dir_i), .chan_compare_state_o(st), .first_timer_run_o(run0),
      .second_timer_run_o(run1), .first_timer_shadow_enable_o(se0),
      .second_timer_shadow_enable_o(se1), .first_timer_tick_o(tk0), .second_timer_tick_o(tk1));
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task conclude();
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // h pulses the hardware stop at the edge that takes the request
   task wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic h);
      int i;
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      sel_i <= bs;
      dat_i <= {16'h0000, d};
      hw_i <= h;
      i = 0;
      do
      begin
         @(posedge clk_i);
         hw_i <= 0;
         i++;
      end
      while (ack_o !== 1'b1 && i < 20);
      rd = dat_o[15:0];
      cyc_i <= 0;
      stb_i <= 0;
      we_i <= 0;
      if (i >= 20)
      begin
         fail_count++;
         conclude();
      end
   endtask
   // strobes only act on the byte lanes that bs enables
   task mod(input logic [15:0] d);
      logic [15:0] m;
      m = d & {{8{bs[1]}}, {8{bs[0]}}};
      wb(1, `CSM_OFS_MODIFY, d, 0);
      for (int c = 0; c < 4; c++)
         if (m[sp[c]] != m[sp[c] + 8])
            es[c] = m[sp[c]];
      chk("state", st, es);
      wb(0, `CSM_OFS_STATE, 0, 0);
      chk("state_rd", rd, es);
   endtask
   task gap(input int lim, input bit b);
      n = 0;
      do @(posedge clk_i) n++; while ((b ? tk1 : tk0) !== 1'b1 && n < lim);
      if (n >= lim)
      begin
         fail_count++;
         conclude();
      end
   endtask
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      wb(0, `CSM_OFS_TCTR, 0, 0);
      chk("ctl_reset", rd, 0);
      repeat (12)
      begin
         lf = nx(lf);
         pat.push_back(lf);
      end
      foreach (pat[i])
      begin
         bs = (i > 4) ? {2'b00, pat[i][5:4]} : 4'h3;
         mod(pat[i]);
      end
      bs = 4'h3;
      wb(1, `CSM_OFS_TCTR, 16'h0282, 0);
      wb(1, `CSM_OFS_RUNCTL, 16'h0101, 0);
      wb(1, `CSM_OFS_TCTR, 16'hcb0b, 0);
      wb(0, `CSM_OFS_TCTR, 0, 0);
      chk("ctl_locked", rd, 16'h1212);
      gap(50, 0);
      gap(50, 0);
      chk("tick_gap", n, 4);
      gap(50, 1);
      gap(50, 1);
      chk("tick1_gap", n, 4);
      wb(1, `CSM_OFS_RUNCTL, 16'h0002, 1);
      chk("run_both", run0, 1);
      wb(0, 8'h20, 0, 1);
      chk("unmapped", rd, 0);
      chk("run_hw", run0, 0);
      dir_i <= 1;
      wb(1, `CSM_OFS_RUNCTL, 16'h0200, 0);
      chk("run1_stop", run1, 0);
      wb(1, `CSM_OFS_TCTR, 16'hcb0b, 0);
      chk("tick1_idle", tk1, 0);
      wb(1, `CSM_OFS_RUNCTL, 16'h0404, 0);
      chk("ste_set", {se1, se0}, 2'b11);
      @(posedge clk_i) sd_i <= 1;
      @(posedge clk_i) sd_i <= 0;
      wb(0, `CSM_OFS_TCTR, 0, 0);
      chk("ctl_open", rd, 16'h2b4b);
      chk("ste_done", {se1, se0}, 2'b10);
      wb(1, `CSM_OFS_RUNCTL, 16'h0001, 0);
      gap(3000, 0);
      gap(3000, 0);
      chk("tick_gap_pre", n, 2048);
      // second reset in mid-run: everything must come back to its reset value
      rst_i <= 1;
      dir_i <= 0;
      es = 4'h0;
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      chk("run_rst", run0, 0);
      chk("ste_rst", se1, 0);
      wb(0, `CSM_OFS_TCTR, 0, 0);
      chk("ctl_rst", rd, 0);
      chk("state_rst", st, 0);
      mod(16'h0047);
      conclude();
   end
endmodule

// >>> testbench/csm_checker.sv
// property checker for csm_top: strobes, channel states, run bit, ticks
// assumes one clock, synchronous active-high reset
`include "csm_defs.vh"
module csm_checker
(
   input logic        clk_i,
   input logic        rst_i,
   input logic        cyc_i,
   input logic        stb_i,
   input logic        we_i,
   input logic [7:0]  adr_i,
   input logic [3:0]  sel_i,
   input logic [31:0] dat_i,
   input logic        ack_o,
   input logic [3:0]  chan_compare_state_o,
   input logic        first_timer_run_o,
   input logic        first_timer_tick_o,
   input logic        first_timer_hw_stop_i
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic        tk, mw, rc;
   logic [15:0] d;
   logic [3:0]  s;
   assign tk = cyc_i & stb_i & ~ack_o;
   assign mw = tk & we_i & ((adr_i & 8'hfc) == `CSM_OFS_MODIFY);
   assign rc = tk & we_i & ((adr_i & 8'hfc) == `CSM_OFS_RUNCTL);
   // strobes only count on enabled byte lanes
   assign d = dat_i[15:0] & {{8{sel_i[1]}}, {8{sel_i[0]}}};
   assign s = chan_compare_state_o;
   sequence s_ack; ack_o ##1 !ack_o; endsequence
   property p_ack; tk |=> s_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack not one pulse");
   property p_clr0; mw && d[8] && !d[0] |=> !s[0]; endproperty
   a_clr0: assert property (p_clr0) else $error("ch0 not cleared");
   property p_clr1; mw && d[9] && !d[1] |=> !s[1]; endproperty
   a_clr1: assert property (p_clr1) else $error("ch1 not cleared");
   property p_clr2; mw && d[10] && !d[2] |=> !s[2]; endproperty
   a_clr2: assert property (p_clr2) else $error("ch2 not cleared");
   property p_clr3; mw && d[14] && !d[6] |=> !s[3]; endproperty
   a_clr3: assert property (p_clr3) else $error("ch3 not cleared");
   property p_set0; mw && d[0] && !d[8] |=> s[0]; endproperty
   a_set0: assert property (p_set0) else $error("ch0 not set");
   property p_both; mw && d[0] && d[8] |=> s[0] == $past(s[0]); endproperty
   a_both: assert property (p_both) else $error("ch0 changed");
   property p_idle; !mw |=> $stable(s); endproperty
   a_idle: assert property (p_idle) else $error("state moved");
   // any two of start, stop and hardware stop in one cycle
   property p_conc;
      rc && ((d[0] && d[1]) || ((d[0] || d[1]) && first_timer_hw_stop_i))
         |=> $stable(first_timer_run_o);
   endproperty
   a_conc: assert property (p_conc) else $error("run moved");
   property p_tick; !first_timer_run_o [*2] |-> !first_timer_tick_o; endproperty
   a_tick: assert property (p_tick) else $error("tick while stopped");
endmodule

bind csm_top csm_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
   .ack_o, .chan_compare_state_o, .first_timer_run_o, .first_timer_tick_o, .first_timer_hw_stop_i);
